/* design/eif_pkg.sv */
package eif_pkg;

  // Number of external interrupt channels handled here.
  localparam int EIF_NCH = 2;

  // Register indices; the bus byte address is four times the index.
  localparam logic [13:0] EIF_IDX_CTRL1 = 14'h0fd8;
  localparam logic [13:0] EIF_IDX_CTRL2 = 14'h0fd9;
  localparam logic [13:0] EIF_IDX_GATE  = 14'h0fdc;
  localparam logic [13:0] EIF_IDX_MODE  = 14'h0fdd;
  localparam logic [13:0] EIF_IDX_STAT  = 14'h0fde;
  localparam logic [13:0] EIF_IDX_MASK  = 14'h0fdf;

  // Control register field positions.
  localparam int EIF_NC_LSB  = 0;
  localparam int EIF_ES_LSB  = 2;
  localparam int EIF_LVL_BIT = 4;

  // Mode register: set while the part runs in slow run or slow sleep mode.
  localparam int EIF_MODE_SLOW_BIT = 0;

  // Values after reset.
  localparam logic [1:0] EIF_RST_FIELD = 2'h0;
  localparam logic [1:0] EIF_RST_BITS  = 2'h0;

  // Edge select codes.
  typedef enum logic [1:0] {
    EIF_ES_RISE = 2'h0,
    EIF_ES_FALL = 2'h1,
    EIF_ES_BOTH = 2'h2,
    EIF_ES_RSVD = 2'h3
  } eif_es_e;

  // Fast mode sampling divider minus one, indexed by the sample-rate code.
  localparam logic [3:0] EIF_NC_DIVM1 [4] = '{4'h0, 4'h3, 4'h7, 4'hf};

  // Low-frequency clock edges per sampling tick in slow modes, minus one.
  localparam logic [1:0] EIF_LF_DIVM1 = 2'h3;

  // Consecutive agreeing sampling ticks before the filtered level moves.
  localparam int EIF_FILT_SAMPLES = 3;

endpackage

/* design/eif_filter.sv */
`timescale 1ns/10ps
module eif_filter
  import eif_pkg::*;
#(
  parameter int SAMPLES = eif_pkg::EIF_FILT_SAMPLES
)
(
  // Clock and reset.
  input  wire logic sys_clk,
  input  wire logic rstn,
  // Sampling tick and raw pin level.
  input  wire logic tick,
  input  wire logic din,
  // Filtered level.
  output logic      level
);

  localparam int CW = $clog2(SAMPLES + 1);
  localparam logic [CW-1:0] LAST = CW'(SAMPLES - 1);

  logic [CW-1:0] cnt;

  // A new level must be seen on SAMPLES ticks in a row; any tick that
  // agrees with the old level restarts the count, so short pulses vanish.
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      level <= 1'b0;
      cnt   <= '0;
    end
    else if (tick)
    begin
      if (din == level)
        cnt <= '0; // RULE13
      else if (cnt == LAST)
      begin
        level <= din; // RULE13
        cnt   <= '0;
      end
      else
        cnt <= cnt + CW'(1);
    end
  end

  // The level only ever moves to the value the pin held a cycle before.
  property p_filter_follows;
    @(posedge sys_clk) disable iff (!rstn)
      (level != $past(level)) |-> ($past(din) == level);
  endproperty
  a_filter_follows: assert property (p_filter_follows) // RULE13
    else $error("filtered level moved against the pin");

endmodule

/* design/eif_top.sv */
// Our own choice: register access over APB.
`timescale 1ns/10ps
// Summary of operation
// (RULE1) Read-only level flag holds the filtered level at the last request.
// (RULE2) Edge select 00 rising, 01 falling, 10 both edges, 11 reserved.
// (RULE3) Fast modes: sample-rate codes give clock divided by 1, 4, 8, 16.
// (RULE4) Slow modes: sample at low-frequency clock over four, any code.
// (RULE5) Bits 7 to 5 of each control register read as zero.
// (RULE6) A second channel behaves exactly like the first one.
// (RULE7) Software disables the interrupt before changing the operating mode.
// (RULE8) Fast to slow: software waits 12 low-frequency periods, clears latch.
// (RULE9) Slow to fast: software waits 2 gear plus 3 switch periods, clears.
// (RULE10) Software disables the channel interrupt before rewriting control.
// (RULE11) Flag and top bits read-only; fields writable; all reset to zero.
// (RULE12) Clock gate bit low stops the channel and ignores control writes.
// (RULE13) Filter output moves only after several agreeing samples.
module eif_top
  import eif_pkg::*;
#(
  parameter int NCH     = eif_pkg::EIF_NCH,
  parameter int SAMPLES = eif_pkg::EIF_FILT_SAMPLES
)
(
  // Clock and reset.
  input  wire logic                 sys_clk,
  input  wire logic                 rstn,
  // APB slave.
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [15:0]          paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // External pins and the low-frequency clock, sampled as levels.
  input  wire logic [NCH-1:0]       ext_irq_pin,
  input  wire logic                 low_freq_clock,
  // Requests toward the interrupt latch and the summary interrupt.
  output logic      [NCH-1:0]       irq_req,
  output logic                      irq
);

  // Per channel configuration and state.
  logic [1:0]     edge_sel   [NCH];
  logic [1:0]     rate_sel   [NCH];
  logic [NCH-1:0] level_flag;
  logic [NCH-1:0] clock_gate;
  logic           slow_mode;
  logic [NCH-1:0] irq_status;
  logic [NCH-1:0] irq_mask;

  logic [NCH-1:0] filt;
  logic [NCH-1:0] filt_prev;
  logic [NCH-1:0] tick;
  logic [NCH-1:0] req_evt;
  logic [3:0]     div_cnt    [NCH];

  logic           lf_prev;
  logic [1:0]     lf_cnt;
  logic           lf_tick;

  // Bus decode.
  logic [13:0]    idx;
  logic           setup;
  logic           wr_acc;
  logic           hit;
  logic [31:0]    rd_val;
  logic [NCH-1:0] ctrl_wr;

  assign idx    = paddr[15:2];
  assign setup  = psel & ~penable;
  assign wr_acc = psel & penable & pready & pwrite & pstrb[0];

  // Address decode and read data assembly.
  always_comb
  begin
    hit    = 1'b1;
    rd_val = 32'h0000_0000; // RULE5
    unique case (idx)
      EIF_IDX_CTRL1:
      begin
        rd_val[EIF_LVL_BIT]             = level_flag[0]; // RULE1
        rd_val[EIF_ES_LSB +: 2]         = edge_sel[0];
        rd_val[EIF_NC_LSB +: 2]         = rate_sel[0]; // RULE5
      end
      EIF_IDX_CTRL2:
      begin
        rd_val[EIF_LVL_BIT]             = level_flag[1]; // RULE6
        rd_val[EIF_ES_LSB +: 2]         = edge_sel[1];
        rd_val[EIF_NC_LSB +: 2]         = rate_sel[1]; // RULE5
      end
      EIF_IDX_GATE: rd_val[NCH-1:0]      = clock_gate;
      EIF_IDX_MODE: rd_val[EIF_MODE_SLOW_BIT] = slow_mode;
      EIF_IDX_STAT: rd_val[NCH-1:0]      = irq_status;
      EIF_IDX_MASK: rd_val[NCH-1:0]      = irq_mask;
      default:      hit                  = 1'b0;
    endcase
  end

  // The answer is prepared in the setup cycle, so every access completes
  // with no wait state and all bus outputs come from flip-flops.
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup & ~hit;
      prdata  <= (setup & ~pwrite) ? rd_val : 32'h0000_0000;
    end
  end

  // Shared control registers: clock gates, operating mode and mask.
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      clock_gate <= '0;
      slow_mode  <= 1'b0;
      irq_mask   <= '0;
    end
    else if (wr_acc)
    begin
      if (idx == EIF_IDX_GATE)
        clock_gate <= pwdata[NCH-1:0];
      if (idx == EIF_IDX_MODE)
        slow_mode <= pwdata[EIF_MODE_SLOW_BIT];
      if (idx == EIF_IDX_MASK)
        irq_mask <= pwdata[NCH-1:0];
    end
  end

  // Low-frequency clock arrives as a level; count its rising edges so that
  // slow-mode sampling happens on every fourth one.
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      lf_prev <= 1'b0;
      lf_cnt  <= EIF_RST_FIELD;
    end
    else
    begin
      lf_prev <= low_freq_clock;
      if (low_freq_clock & ~lf_prev)
        lf_cnt <= lf_cnt + 2'h1;
    end
  end

  assign lf_tick = low_freq_clock & ~lf_prev & (lf_cnt == EIF_LF_DIVM1);

  // Sticky status: hardware set wins over a software write-one clear.
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      irq_status <= '0;
    else if (wr_acc && idx == EIF_IDX_STAT)
      irq_status <= (irq_status & ~pwdata[NCH-1:0]) | req_evt;
    else
      irq_status <= irq_status | req_evt;
  end

  // Summary interrupt and per-channel request pulses, both registered.
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      irq     <= 1'b0;
      irq_req <= '0;
    end
    else
    begin
      irq     <= |((irq_status | req_evt) & irq_mask);
      irq_req <= req_evt;
    end
  end

  // One identical slice per channel.
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++)
    begin : g_ch // RULE6
      logic rise;
      logic fall;
      logic match;

      // Writes are only honoured while the channel clock is on, since the
      // gated slice would not see them.
      assign ctrl_wr[gi] = wr_acc & clock_gate[gi] &
                           (idx == (EIF_IDX_CTRL1 + 14'(gi))); // RULE12

      always_ff @(posedge sys_clk)
      begin
        if (!rstn)
        begin
          edge_sel[gi] <= EIF_RST_FIELD; // RULE11
          rate_sel[gi] <= EIF_RST_FIELD; // RULE11
        end
        else if (ctrl_wr[gi])
        begin
          edge_sel[gi] <= pwdata[EIF_ES_LSB +: 2];
          rate_sel[gi] <= pwdata[EIF_NC_LSB +: 2];
        end
      end

      // Sampling divider; a compare with >= tolerates a smaller code being
      // written while the count is high, at the cost of one early tick.
      always_ff @(posedge sys_clk)
      begin
        if (!rstn)
          div_cnt[gi] <= 4'h0;
        else if (!clock_gate[gi] || slow_mode || tick[gi])
          div_cnt[gi] <= 4'h0;
        else
          div_cnt[gi] <= div_cnt[gi] + 4'h1;
      end

      always_comb
      begin
        if (!clock_gate[gi])
          tick[gi] = 1'b0; // RULE12
        else if (slow_mode)
          tick[gi] = lf_tick; // RULE4
        else
          tick[gi] = div_cnt[gi] >= EIF_NC_DIVM1[rate_sel[gi]]; // RULE3
      end

      eif_filter #(
        .SAMPLES (SAMPLES)
      ) u_filter (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .tick    (tick[gi]),
        .din     (ext_irq_pin[gi]),
        .level   (filt[gi])
      );

      always_ff @(posedge sys_clk)
      begin
        if (!rstn)
          filt_prev[gi] <= 1'b0;
        else
          filt_prev[gi] <= filt[gi];
      end

      // Edge qualification on the filtered signal.
      assign rise = filt[gi] & ~filt_prev[gi];
      assign fall = ~filt[gi] & filt_prev[gi];
      always_comb
      begin
        unique case (edge_sel[gi])
          EIF_ES_RISE: match = rise; // RULE2
          EIF_ES_FALL: match = fall; // RULE2
          EIF_ES_BOTH: match = rise | fall; // RULE2
          EIF_ES_RSVD: match = 1'b0;
        endcase
      end
      assign req_evt[gi] = match & clock_gate[gi];

      // Level flag holds the filtered level of the last request.
      always_ff @(posedge sys_clk)
      begin
        if (!rstn)
          level_flag[gi] <= 1'b0; // RULE11
        else if (req_evt[gi])
          level_flag[gi] <= filt[gi]; // RULE1
      end

      property p_level_flag;
        @(posedge sys_clk) disable iff (!rstn)
          req_evt[gi] |=> (level_flag[gi] == $past(filt[gi]));
      endproperty
      a_level_flag: assert property (p_level_flag) // RULE1
        else $error("level flag does not hold the request level");

      property p_rise_req;
        @(posedge sys_clk) disable iff (!rstn)
          (clock_gate[gi] && edge_sel[gi] == EIF_ES_RISE && rise)
            |=> irq_req[gi];
      endproperty
      a_rise_req: assert property (p_rise_req) // RULE2
        else $error("rising edge did not raise a request");

      property p_no_fall_req;
        @(posedge sys_clk) disable iff (!rstn)
          (edge_sel[gi] == EIF_ES_RISE && !rise) |=> !irq_req[gi];
      endproperty
      a_no_fall_req: assert property (p_no_fall_req) // RULE2
        else $error("request without a selected edge");

      property p_fast_div4;
        @(posedge sys_clk) disable iff (!rstn)
          (tick[gi] && !slow_mode && clock_gate[gi] && rate_sel[gi] == 2'h1)
            ##1 (!slow_mode && clock_gate[gi] && rate_sel[gi] == 2'h1)[*3]
            |-> ($past(tick[gi], 1) == 1'b0 && $past(tick[gi], 2) == 1'b0);
      endproperty
      a_fast_div4: assert property (p_fast_div4) // RULE3
        else $error("fast sampling tick spacing wrong");

      property p_slow_tick;
        @(posedge sys_clk) disable iff (!rstn)
          (tick[gi] && slow_mode) |-> (low_freq_clock && !lf_prev &&
                                       lf_cnt == EIF_LF_DIVM1);
      endproperty
      a_slow_tick: assert property (p_slow_tick) // RULE4
        else $error("slow sampling tick off the low-frequency clock");

      property p_gate_blocks;
        @(posedge sys_clk) disable iff (!rstn)
          (wr_acc && !clock_gate[gi] &&
           idx == (EIF_IDX_CTRL1 + 14'(gi)))
            |=> ($stable(edge_sel[gi]) && $stable(rate_sel[gi]));
      endproperty
      a_gate_blocks: assert property (p_gate_blocks) // RULE12
        else $error("control write taken with clock gate off");

      property p_reset_zero;
        @(posedge sys_clk)
          $past(!rstn) |-> (edge_sel[gi] == 2'h0 && rate_sel[gi] == 2'h0 &&
                            level_flag[gi] == 1'b0);
      endproperty
      a_reset_zero: assert property (p_reset_zero) // RULE11
        else $error("control fields not zero after reset");
    end
  endgenerate

  property p_top_bits_zero;
    @(posedge sys_clk) disable iff (!rstn)
      (psel && penable && !pwrite &&
       (idx == EIF_IDX_CTRL1 || idx == EIF_IDX_CTRL2))
        |-> (prdata[31:5] == 27'h0 && pready);
  endproperty
  a_top_bits_zero: assert property (p_top_bits_zero) // RULE5
    else $error("unused control bits read nonzero");

endmodule

/* verification/eif_pin_model.sv */
`timescale 1ns/10ps
// Far side of the block: the raw interrupt pins and the slow clock source.
module eif_pin_model #(
  parameter int LF_HALF = 4
)
(
  // Clock.
  input  wire logic       sys_clk,
  // Pins and slow clock.
  output logic      [1:0] ext_irq_pin,
  output logic            low_freq_clock
);
  int lf_cnt = 0;

  // Start quiet so the filters see a defined low level.
  initial
  begin
    ext_irq_pin    = 2'h0;
    low_freq_clock = 1'b0;
  end

  // The slow clock runs free like a crystal; each level lasts LF_HALF cycles.
  always @(posedge sys_clk)
  begin
    lf_cnt <= (lf_cnt == LF_HALF - 1) ? 0 : lf_cnt + 1;
    if (lf_cnt == LF_HALF - 1)
      low_freq_clock <= ~low_freq_clock;
  end

  // Pins move just after an edge, as a synchronised source would.
  task automatic set_pin(input int ch, input logic v);
    @(posedge sys_clk);
    ext_irq_pin[ch] <= v;
  endtask
endmodule

/* verification/tb.sv */
`timescale 1ns/10ps
module tb;
  import eif_pkg::*;
  typedef struct {
    int         ch;
    logic [1:0] es;
    logic [1:0] nc;
    logic       mk;
    logic       er;
    logic       ef;
  } eif_row_s;
  localparam int LFH = 4;
  logic        sys_clk = 1'b0;
  logic        rstn    = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [15:0] paddr   = 16'h0;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  pins;
  logic        lfc;
  logic [1:0]  irq_req;
  logic        irq;
  logic [31:0] r;
  logic        e;
  int          err_count = 0;
  int          samples_checked = 0;
  int          cnt [2] = '{0, 0};
  int          dv [4] = '{1, 4, 8, 16};
  int          lat;
  int          n;
  // Rising, falling, both and reserved codes on both channels, all rates.
  eif_row_s rows [8] = '{
    '{0, 2'h0, 2'h0, 1, 1, 0}, '{0, 2'h1, 2'h1, 0, 0, 1},
    '{0, 2'h2, 2'h2, 1, 1, 1}, '{0, 2'h3, 2'h0, 1, 0, 0},
    '{1, 2'h0, 2'h3, 1, 1, 0}, '{1, 2'h1, 2'h0, 1, 0, 1},
    '{1, 2'h2, 2'h1, 0, 1, 1}, '{1, 2'h3, 2'h2, 1, 0, 0}};

  eif_top dut (.sys_clk(sys_clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_irq_pin(pins), .low_freq_clock(lfc), .irq_req(irq_req),
    .irq(irq));
  eif_pin_model #(.LF_HALF(LFH)) m (.sys_clk(sys_clk),
    .ext_irq_pin(pins), .low_freq_clock(lfc));

  // 250 MHz system clock.
  initial
  begin
    forever #2 sys_clk = ~sys_clk;
  end

  // Request pulses are counted here so none is missed between reads.
  always @(posedge sys_clk)
  begin
    for (int i = 0; i < 2; i++)
      if (irq_req[i] === 1'b1)
        cnt[i] <= cnt[i] + 1;
  end

  task automatic print_verdict();
    if (err_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x)
    begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, x);
    end
  endtask

  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic w, input logic [13:0] idx,
                     input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, 2'h0};
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    if (k >= 50)
      err_count++;
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [13:0] ci(input int ch);
    return (ch == 0) ? EIF_IDX_CTRL1 : EIF_IDX_CTRL2;
  endfunction

  // Moves one pin, then counts requests and notes the first one's delay.
  task automatic phase(input int ch, input logic v);
    int c0;
    c0 = cnt[ch];
    lat = -1;
    m.set_pin(ch, v);
    for (int k = 1; k <= 130; k++)
    begin
      @(posedge sys_clk);
      if (irq_req[ch] === 1'b1 && lat < 0)
        lat = k;
    end
    #1;
    n = cnt[ch] - c0;
  endtask

  // Watchdog well beyond the expected run of a few thousand cycles.
  initial
  begin
    repeat (30000) @(posedge sys_clk);
    err_count++;
    print_verdict();
  end

  initial
  begin
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    check({31'h0, pready}, 32'h0);
    foreach (rows[i])
    begin
      if (i < 6)
      begin
        apb(1'b0, EIF_IDX_CTRL1 + i[13:0], 32'h0);
        check(r, 32'h0);
      end
    end
    // Unmapped place: error response and zero data.
    apb(1'b0, 14'h0010, 32'h0);
    check({31'h0, e}, 32'h1);
    check(r, 32'h0);
    apb(1'b1, EIF_IDX_CTRL1, 32'h0b);
    apb(1'b0, EIF_IDX_CTRL1, 32'h0);
    check(r, 32'h0);
    phase(0, 1'b1);
    check(n, 0);
    phase(0, 1'b0);
    apb(1'b1, EIF_IDX_GATE, 32'h3);
    apb(1'b1, EIF_IDX_CTRL1, 32'hff);
    apb(1'b0, EIF_IDX_CTRL1, 32'h0);
    check(r, 32'h0f);
    apb(1'b1, EIF_IDX_CTRL2, 32'he6);
    apb(1'b0, EIF_IDX_CTRL2, 32'h0);
    check(r, 32'h06);
    foreach (rows[i])
    begin
      apb(1'b1, EIF_IDX_MASK, 32'h0);
      apb(1'b1, ci(rows[i].ch), {28'h0, rows[i].es, rows[i].nc});
      apb(1'b1, EIF_IDX_STAT, 32'h3);
      apb(1'b1, EIF_IDX_MASK, {31'h0, rows[i].mk} << rows[i].ch);
      phase(rows[i].ch, 1'b1);
      check(n, rows[i].er);
      if (rows[i].er)
        check({31'h0, lat >= 2 * dv[rows[i].nc] + 1 &&
               lat <= 3 * dv[rows[i].nc] + 3}, 32'h1);
      check({31'h0, irq}, {31'h0, rows[i].mk & rows[i].er});
      apb(1'b0, EIF_IDX_STAT, 32'h0);
      check(r, {31'h0, rows[i].er} << rows[i].ch);
      apb(1'b0, ci(rows[i].ch), 32'h0);
      if (rows[i].er)
        check(r[4], 32'h1);
      apb(1'b1, EIF_IDX_STAT, 32'h3);
      repeat (2) @(posedge sys_clk);
      check({31'h0, irq}, 32'h0);
      phase(rows[i].ch, 1'b0);
      check(n, rows[i].ef);
      apb(1'b0, ci(rows[i].ch), 32'h0);
      if (rows[i].ef)
        check(r[4], 32'h0);
    end
    // A pulse shorter than the agreeing run is swallowed.
    apb(1'b1, EIF_IDX_CTRL1, 32'h08);
    m.set_pin(0, 1'b1);
    m.set_pin(0, 1'b0);
    phase(0, 1'b0);
    check(n, 0);
    apb(1'b1, EIF_IDX_MASK, 32'h0);
    apb(1'b1, EIF_IDX_CTRL1, 32'h03);
    apb(1'b1, EIF_IDX_MODE, 32'h1);
    repeat (12 * 2 * LFH) @(posedge sys_clk);
    apb(1'b1, EIF_IDX_STAT, 32'h3);
    phase(0, 1'b1);
    check(n, 1);
    check({31'h0, lat >= 65 && lat <= 104}, 32'h1);
    phase(0, 1'b0);
    apb(1'b1, EIF_IDX_MODE, 32'h0);
    repeat (20) @(posedge sys_clk);
    apb(1'b1, EIF_IDX_STAT, 32'h3);
    // Channel one still holds a high level flag and a written field here,
    // so a reset in mid-run must visibly bring them back to zero.
    apb(1'b0, EIF_IDX_CTRL1, 32'h0);
    check(r, 32'h13);
    rstn <= 1'b0;
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    check({30'h0, irq, pready}, 32'h0);
    apb(1'b0, EIF_IDX_CTRL1, 32'h0);
    check(r, 32'h0);
    apb(1'b0, EIF_IDX_GATE, 32'h0);
    check(r, 32'h0);
    print_verdict();
  end
endmodule
